// ==== tb_module_uart_with_break_reset.sv ====
// Bench: both ends joined, APB on the host end, user side of the module end
`timescale 1ns/1ps
module tb_module_uart_with_break_reset;
  import umb_pkg::*;
  localparam int HRC = 30, RFC = 20, BUC = 10;
  logic mclk_i = 1'b0, rst_b_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, txv = 1'b0, brk = 1'b0, rxr = 1'b1, gwe = 1'b0, stop2 = 1'b0;
  logic [7:0] paddr = 8'h00, txd = 8'h00, rxd_o, d, d2;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] baud = 16'h01d8, bto = 16'h01a4;
  logic [15:0] bauds[4] = '{16'h3000, 16'h0027, 16'h075f, 16'h01d8};
  umb_par_e pars[4] = '{PAR_EVEN, PAR_NONE, PAR_ODD, PAR_EVEN};
  umb_par_e par = PAR_NONE;
  logic pready, pslverr, er, txr, rxv, perr, ferr, srst;
  logic [GIO_N-1:0] gdir = 6'h00, gout = 6'h00, gin = 6'h00, go, goe, gval;
  logic [2*GIO_N-1:0] gpull = 12'h000, gpo;
  int n_fail = 0, check_count = 0, cyc = 0, sr_cnt = 0;
  real t0, e, bt;
  logic [7:0] exp_rx[$];
  umb_link_if link_if();
  umb_dev #(.RST_FILT_CYC(RFC), .BRK_UNIT_CYC(BUC)) umb_dev_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .link(link_if), .stored_baud_setting_i(baud), .par_i(par), .two_stop_i(stop2), .flow_en_i(1'b1),
    .stored_break_timeout_i(bto), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .send_break_i(brk),
    .rx_ready_i(rxr), .rx_data_o(rxd_o), .rx_valid_o(rxv), .rx_perr_o(perr), .rx_ferr_o(ferr),
    .self_reset_o(srst), .gio_cfg_we_i(gwe), .gio_dir_i(gdir), .gio_out_i(gout), .gio_pull_i(gpull),
    .general_io_line_i(gin), .general_io_line_o(go), .general_io_line_oe_o(goe), .gio_pull_o(gpo),
    .gio_val_o(gval));
  umb_host #(.HOST_RST_CYC(HRC)) umb_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link_if),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));
  umb_link_chk #(.HOST_RST_CYC(HRC)) umb_link_chk_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reset_input_pin(link_if.reset_input_pin), .dev_rxd(link_if.dev_rxd), .dev_txd(link_if.dev_txd),
    .request_send_out_n(link_if.request_send_out_n), .clear_send_in_n(link_if.clear_send_in_n));
  always #50 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Module receive results against the queue of bytes the host was given
  always @(posedge mclk_i) begin
    cyc++;
    if (srst === 1'b1) sr_cnt++;
    if (rxv === 1'b1 && exp_rx.size() > 0) chk(32'({ferr, perr, rxd_o}), 32'({2'b00, exp_rx.pop_front()}));
    if (cyc == 100000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    pen <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic host_get(input logic [7:0] x);
    rd = 32'h0000_0000;
    for (int i = 0; i < 4000 && rd[8] !== 1'b1; i++) apb(1'b0, REG_RX, 32'h0000_0000);
    chk(32'(rd[10:0]), {21'h00_0000, 3'b001, x});
  endtask
  task automatic drain();
    for (int i = 0; i < 30000 && exp_rx.size() > 0; i++) @(posedge mclk_i);
    chk(32'(exp_rx.size()), 32'h0000_0000);
    repeat (1200) @(posedge mclk_i);
  endtask
  task automatic dev_send(input logic [7:0] x);
    logic [11:0] b;
    int nb;
    real ts;
    b = (par == PAR_NONE) ? {3'b111, x, 1'b0} : {2'b11, ^x ^ (par == PAR_ODD), x, 1'b0};
    nb = 10 + int'(par != PAR_NONE) + int'(stop2);
    bt = 4096000.0 / baud;
    txd <= x;
    txv <= 1'b1;
    @(posedge mclk_i);
    while (!(txr === 1'b1 && link_if.clear_send_in_n === 1'b0)) @(posedge mclk_i);
    txv <= 1'b0;
    @(negedge link_if.dev_txd);
    ts = $realtime;
    for (int i = 0; i < nb; i++) begin
      #(ts + (i + 0.5) * bt - $realtime);
      chk(32'(link_if.dev_txd), 32'(b[i]));
    end
    @(posedge txr);
    e = $realtime - ts - nb * bt;
    chk(32'(e < 200.0 && e > -200.0), 32'h0000_0001);
    @(posedge mclk_i);
  endtask
  initial begin
    void'($urandom(32'h0de2_1acd));
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    chk(32'({txr, srst, goe, gpo}), 32'({2'b10, 6'h00, GIO_PULL_RST}));
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_01d8);
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // Every parity mode, both stop counts, fastest then slowest then middle rates
    for (int k = 0; k < 4; k++) begin
      baud <= bauds[k];
      par <= pars[k];
      stop2 <= k[0];
      apb(1'b1, REG_CTRL, {12'h000, 1'b1, k[0], pars[k], bauds[k]});
      repeat (2) begin
        d = 8'($urandom);
        exp_rx.push_back(d);
        apb(1'b1, REG_TX, {24'h00_0000, d});
      end
      d = 8'($urandom);
      dev_send(d);
      host_get(d);
      drain();
    end
    // Fill the buffer while the module holds request-to-send high
    rxr <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(32'(link_if.request_send_out_n), 32'h0000_0001);
    repeat (16) begin
      d = 8'($urandom);
      exp_rx.push_back(d);
      apb(1'b1, REG_TX, {24'h00_0000, d});
    end
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk(32'(rd[1:0]), 32'h0000_0002);
    chk(32'(link_if.dev_rxd), 32'h0000_0001);
    rxr <= 1'b1;
    for (int i = 0; i < 9000 && exp_rx.size() > 8; i++) @(posedge mclk_i);
    rxr <= 1'b0;
    repeat (3000) @(posedge mclk_i);
    rxr <= 1'b1;
    drain();
    apb(1'b0, REG_STAT, 32'h0000_0000);
    chk(32'(rd[1:0]), 32'h0000_0001);
    // Host holding full: second byte must wait for clear-to-send
    d = 8'($urandom);
    d2 = 8'($urandom);
    dev_send(d);
    chk(32'(link_if.clear_send_in_n), 32'h0000_0001);
    fork
      dev_send(d2);
      begin
        repeat (500) @(posedge mclk_i);
        chk(32'(link_if.dev_txd), 32'h0000_0001);
        host_get(d);
      end
    join
    host_get(d2);
    brk <= 1'b1;
    @(posedge mclk_i);
    brk <= 1'b0;
    @(negedge link_if.dev_txd);
    t0 = $realtime;
    @(posedge link_if.dev_txd);
    e = $realtime - t0 - 24.0 * 4096000.0 / baud;
    chk(32'(e < 200.0 && e > -200.0), 32'h0000_0001);
    repeat (1200) @(posedge mclk_i);
    apb(1'b0, REG_RX, 32'h0000_0000);
    gdir <= 6'($urandom);
    gout <= 6'($urandom);
    gpull <= 12'($urandom);
    gin <= 6'($urandom);
    gwe <= 1'b1;
    @(posedge mclk_i);
    gwe <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(32'({goe, go, gpo, gval}), 32'({gdir, gout, gpull, gin}));
    // Break shorter than the stored timeout leaves the module running
    sr_cnt = 0;
    apb(1'b1, REG_CMD, 32'h0000_0002);
    @(posedge link_if.dev_rxd);
    repeat (10) @(posedge mclk_i);
    chk(32'(sr_cnt), 32'h0000_0000);
    bto <= 16'h0003;
    fork
      apb(1'b1, REG_CMD, 32'h0000_0002);
      begin
        @(negedge link_if.dev_rxd);
        t0 = $realtime;
      end
    join
    @(posedge srst);
    e = ($realtime - t0) / 100.0 - (3 + 1) * BUC;
    chk(32'(e > -2.5 && e < 2.5), 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    chk(32'({goe, gpo}), 32'({6'h00, GIO_PULL_RST}));
    @(posedge link_if.dev_rxd);
    repeat (1200) @(posedge mclk_i);
    fork
      begin
        apb(1'b1, REG_CMD, 32'h0000_0001);
        apb(1'b0, REG_CMD, 32'h0000_0000);
        chk(32'(rd[0]), 32'h0000_0001);
      end
      begin
        @(posedge link_if.reset_input_pin);
        t0 = $realtime;
        @(posedge srst);
        e = ($realtime - t0) / 100.0 - RFC;
        chk(32'(e > -1.5 && e < 1.5), 32'h0000_0001);
        @(negedge link_if.reset_input_pin);
        repeat (2) @(posedge mclk_i);
        chk(32'(srst), 32'h0000_0000);
      end
    join
    end_sim();
  end
endmodule

// ==== umb_dev.sv ====
// Module end: serial engine, reset filter, break reset and general I/O lines
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module umb_serial (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic clr_i,
  input wire logic [15:0] baud_i,
  input wire umb_pkg::umb_par_e par_i,
  input wire logic two_stop_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_go_i,
  input wire logic brk_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_perr_o,
  output logic rx_ferr_o
);
  import umb_pkg::*;
  typedef struct packed {
    umb_tx_e ts;
    logic [16:0] tacc;
    logic [4:0] tcnt;
    logic [7:0] tsh;
    logic tpar;
    logic txd;
    logic trdy;
    umb_rx_e rs;
    logic [16:0] racc;
    logic [2:0] rcnt;
    logic [7:0] rsh;
    logic rpar;
    logic [7:0] rdat;
    logic rvld;
    logic rperr;
    logic rferr;
  } umb_ser_s;
  localparam umb_ser_s SER_RST = '{ts: TX_IDLE, txd: 1'b1, trdy: 1'b1, rs: RX_IDLE, default: '0};
  umb_ser_s s_q, s_d;
  logic [17:0] tn, rn;

  always_comb begin
    s_d = s_q;
    s_d.rvld = 1'b0;
    tn = umb_nco(s_q.tacc, baud_i);
    rn = umb_nco(s_q.racc, baud_i);
    if (s_q.ts != TX_IDLE) begin
      s_d.tacc = tn[16:0];
    end
    case (s_q.ts)
      TX_IDLE: begin
        if (brk_i) begin
          s_d.ts = TX_BRK;
          s_d.tacc = '0;
          s_d.tcnt = '0;
          s_d.txd = 1'b0;
          s_d.trdy = 1'b0;
        end else if (tx_valid_i && tx_go_i) begin
          s_d.ts = TX_START;
          s_d.tsh = tx_data_i;
          s_d.tpar = (^tx_data_i) ^ (par_i == PAR_ODD);
          s_d.tacc = '0;
          s_d.txd = 1'b0;
          s_d.trdy = 1'b0;
        end
      end
      TX_START: begin
        if (tn[17]) begin
          s_d.ts = TX_DATA;
          s_d.txd = s_q.tsh[0];
          s_d.tsh = s_q.tsh >> 1;
          s_d.tcnt = '0;
        end
      end
      TX_DATA: begin
        if (tn[17]) begin
          if (s_q.tcnt == 5'h07) begin
            s_d.ts = (par_i == PAR_NONE) ? TX_STOP : TX_PAR;
            s_d.txd = (par_i == PAR_NONE) ? 1'b1 : s_q.tpar;
            s_d.tcnt = '0;
          end else begin
            s_d.txd = s_q.tsh[0];
            s_d.tsh = s_q.tsh >> 1;
            s_d.tcnt = s_q.tcnt + 5'h01;
          end
        end
      end
      TX_PAR: begin
        if (tn[17]) begin
          s_d.ts = TX_STOP;
          s_d.txd = 1'b1;
        end
      end
      TX_STOP: begin
        if (tn[17]) begin
          if (s_q.tcnt == {4'h0, two_stop_i}) begin
            s_d.ts = TX_IDLE;
            s_d.trdy = 1'b1;
          end else begin
            s_d.tcnt = s_q.tcnt + 5'h01;
          end
        end
      end
      TX_BRK: begin
        if (tn[17]) begin
          if (s_q.tcnt == TX_BRK_BITS - 5'h01) begin
            s_d.ts = TX_IDLE;
            s_d.txd = 1'b1;
            s_d.trdy = 1'b1;
          end else begin
            s_d.tcnt = s_q.tcnt + 5'h01;
          end
        end
      end
      default: s_d = SER_RST;
    endcase
    if (s_q.rs != RX_IDLE) begin
      s_d.racc = rn[16:0];
    end
    case (s_q.rs)
      RX_IDLE: begin
        if (!rxd_i) begin
          s_d.rs = RX_START;
          s_d.racc = BAUD_HALF;
        end
      end
      RX_START: begin
        if (rn[17]) begin
          s_d.rs = rxd_i ? RX_IDLE : RX_DATA;
          s_d.rcnt = '0;
        end
      end
      RX_DATA: begin
        if (rn[17]) begin
          s_d.rsh = {rxd_i, s_q.rsh[7:1]};
          s_d.rcnt = s_q.rcnt + 3'h1;
          if (s_q.rcnt == 3'h7) begin
            s_d.rs = (par_i == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (rn[17]) begin
          s_d.rpar = rxd_i;
          s_d.rs = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rn[17]) begin
          s_d.rs = RX_IDLE;
          s_d.rdat = s_q.rsh;
          s_d.rvld = 1'b1;
          s_d.rferr = !rxd_i;
          s_d.rperr = (par_i != PAR_NONE) && (((^s_q.rsh) ^ s_q.rpar) != (par_i == PAR_ODD));
        end
      end
      default: s_d = SER_RST;
    endcase
    if (clr_i) begin
      s_d = SER_RST;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= SER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign txd_o = s_q.txd;
  assign tx_ready_o = s_q.trdy;
  assign rx_data_o = s_q.rdat;
  assign rx_valid_o = s_q.rvld;
  assign rx_perr_o = s_q.rperr;
  assign rx_ferr_o = s_q.rferr;
endmodule

module umb_dev #(
  parameter int RST_FILT_CYC = umb_pkg::RST_FILT_CYC,
  parameter int BRK_UNIT_CYC = umb_pkg::BRK_UNIT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  umb_link_if.dev link,
  input wire logic [15:0] stored_baud_setting_i,
  input wire umb_pkg::umb_par_e par_i,
  input wire logic two_stop_i,
  input wire logic flow_en_i,
  input wire logic [15:0] stored_break_timeout_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic send_break_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_perr_o,
  output logic rx_ferr_o,
  output logic self_reset_o,
  input wire logic gio_cfg_we_i,
  input wire logic [umb_pkg::GIO_N-1:0] gio_dir_i,
  input wire logic [umb_pkg::GIO_N-1:0] gio_out_i,
  input wire logic [2*umb_pkg::GIO_N-1:0] gio_pull_i,
  input wire logic [umb_pkg::GIO_N-1:0] general_io_line_i,
  output logic [umb_pkg::GIO_N-1:0] general_io_line_o,
  output logic [umb_pkg::GIO_N-1:0] general_io_line_oe_o,
  output logic [2*umb_pkg::GIO_N-1:0] gio_pull_o,
  output logic [umb_pkg::GIO_N-1:0] gio_val_o
);
  import umb_pkg::*;
  typedef struct packed {
    logic [15:0] filt;
    logic [15:0] unit;
    logic [15:0] brk;
    logic rst;
    logic rts_n;
    logic [GIO_N-1:0] oe;
    logic [GIO_N-1:0] out;
    logic [2*GIO_N-1:0] pull;
    logic [GIO_N-1:0] val;
  } umb_dev_s;
  localparam umb_dev_s DEV_RST = '{rts_n: 1'b1, pull: GIO_PULL_RST, default: '0};
  umb_dev_s d_q, d_d;
  logic tx_go;

  // Sending waits for clear-to-send when flow control is on
  assign tx_go = tx_valid_i && !d_q.rst && (!flow_en_i || !link.clear_send_in_n);

  umb_serial u_ser (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .clr_i(d_q.rst),
    .baud_i(stored_baud_setting_i),
    .par_i(par_i),
    .two_stop_i(two_stop_i),
    .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i),
    .tx_go_i(tx_go),
    .brk_i(send_break_i && !d_q.rst),
    .rxd_i(link.dev_rxd),
    .txd_o(link.dev_txd),
    .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o),
    .rx_perr_o(rx_perr_o),
    .rx_ferr_o(rx_ferr_o)
  );

  always_comb begin
    d_d = d_q;
    d_d.rst = 1'b0;
    d_d.val = general_io_line_i;
    if (link.reset_input_pin) begin
      if (d_q.filt == 16'(RST_FILT_CYC - 1)) begin
        d_d.rst = 1'b1;
      end else begin
        d_d.filt = d_q.filt + 16'h0001;
      end
    end else begin
      d_d.filt = '0;
    end
    if (link.dev_rxd || d_q.rst) begin
      d_d.unit = '0;
      d_d.brk = '0;
    end else if (d_q.unit == 16'(BRK_UNIT_CYC - 1)) begin
      d_d.unit = '0;
      if (d_q.brk >= stored_break_timeout_i) begin
        d_d.rst = 1'b1;
        d_d.brk = '0;
      end else begin
        d_d.brk = d_q.brk + 16'h0001;
      end
    end else begin
      d_d.unit = d_q.unit + 16'h0001;
    end
    d_d.rts_n = !rx_ready_i || d_d.rst;
    if (d_d.rst) begin
      d_d.oe = '0;
      d_d.out = '0;
      d_d.pull = GIO_PULL_RST;
    end else if (gio_cfg_we_i) begin
      d_d.oe = gio_dir_i;
      d_d.out = gio_out_i;
      d_d.pull = gio_pull_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      d_q <= DEV_RST;
    end else begin
      d_q <= d_d;
    end
  end

  assign link.request_send_out_n = d_q.rts_n;
  assign self_reset_o = d_q.rst;
  assign general_io_line_o = d_q.out;
  assign general_io_line_oe_o = d_q.oe;
  assign gio_pull_o = d_q.pull;
  assign gio_val_o = d_q.val;
endmodule

// ==== umb_host.sv ====
// Host end: APB registers, transmit FIFO, reset pulse and receive holding
`timescale 1ns/1ps
module umb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } umb_fifo_s;
  umb_fifo_s f_q, f_d;
  logic [W-1:0] mem [D];
  logic wr_go, rd_go;

  assign wr_ready_o = (f_q.wp ^ f_q.rp) != {1'b1, {AW{1'b0}}};
  assign rd_valid_o = f_q.wp != f_q.rp;
  assign rd_data_o = mem[f_q.rp[AW-1:0]];
  assign wr_go = wr_valid_i && wr_ready_o;
  assign rd_go = rd_ready_i && rd_valid_o;

  always_comb begin
    f_d = f_q;
    if (wr_go) begin
      f_d.wp = f_q.wp + (AW+1)'(1);
    end
    if (rd_go) begin
      f_d.rp = f_q.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_go) begin
      mem[f_q.wp[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule

module umb_host #(
  parameter int HOST_RST_CYC = umb_pkg::HOST_RST_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  umb_link_if.host link,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import umb_pkg::*;
  typedef struct packed {
    logic [15:0] baud;
    umb_par_e par;
    logic stop2;
    logic flow;
    logic [16:0] rcnt;
    logic rpin;
    logic brk;
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic [9:0] hold;
    logic hv;
    logic ovr;
  } umb_host_s;
  localparam umb_host_s HOST_RST = '{baud: BAUD_RST, par: PAR_NONE, default: '0};
  umb_host_s h_q, h_d;
  logic acc, done, push, go, t_rdy, f_wr_rdy, f_rd_vld, r_vld, r_perr, r_ferr;
  logic [7:0] f_data, r_data;

  assign acc = psel_i && penable_i;
  assign done = acc && h_q.ready;
  assign push = done && pwrite_i && (paddr_i == REG_TX);
  assign go = !h_q.flow || !link.request_send_out_n;

  umb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .wr_data_i(pwdata_i[7:0]),
    .wr_valid_i(push),
    .wr_ready_o(f_wr_rdy),
    .rd_data_o(f_data),
    .rd_valid_o(f_rd_vld),
    .rd_ready_i(t_rdy && go && !h_q.brk)
  );

  umb_serial u_ser (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .clr_i(1'b0),
    .baud_i(h_q.baud),
    .par_i(h_q.par),
    .two_stop_i(h_q.stop2),
    .tx_data_i(f_data),
    .tx_valid_i(f_rd_vld),
    .tx_go_i(f_rd_vld && go),
    .brk_i(h_q.brk),
    .rxd_i(link.dev_txd),
    .txd_o(link.dev_rxd),
    .tx_ready_o(t_rdy),
    .rx_data_o(r_data),
    .rx_valid_o(r_vld),
    .rx_perr_o(r_perr),
    .rx_ferr_o(r_ferr)
  );

  always_comb begin
    h_d = h_q;
    h_d.brk = 1'b0;
    h_d.ready = 1'b0;
    if (acc && !h_q.ready && (paddr_i != REG_TX || !pwrite_i || f_wr_rdy)) begin
      h_d.ready = 1'b1;
      h_d.err = 1'b0;
      h_d.rdata = '0;
      case (paddr_i)
        REG_CTRL: h_d.rdata = {12'h000, h_q.flow, h_q.stop2, h_q.par, h_q.baud};
        REG_TX: h_d.rdata = '0;
        REG_RX: h_d.rdata = {21'h00_0000, h_q.hold[9:8], h_q.hv, h_q.hold[7:0]};
        REG_CMD: h_d.rdata = {31'h0000_0000, h_q.rpin};
        REG_STAT: h_d.rdata = {26'h000_0000, !t_rdy, h_q.rpin, h_q.ovr, h_q.hv, !f_wr_rdy, !f_rd_vld};
        default: h_d.err = 1'b1;
      endcase
    end
    if (done && pwrite_i) begin
      case (paddr_i)
        REG_CTRL: begin
          h_d.baud = pwdata_i[15:0];
          h_d.par = umb_par_e'(pwdata_i[CTRL_PAR_LSB +: 2]);
          h_d.stop2 = pwdata_i[CTRL_STOP2];
          h_d.flow = pwdata_i[CTRL_FLOW];
        end
        REG_CMD: begin
          h_d.brk = pwdata_i[CMD_BRK];
          if (pwdata_i[CMD_RST]) begin
            h_d.rcnt = 17'(HOST_RST_CYC);
          end
        end
        REG_STAT: begin
          if (pwdata_i[STAT_OVR]) begin
            h_d.ovr = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (done && !pwrite_i && paddr_i == REG_RX) begin
      h_d.hv = 1'b0;
    end
    if (r_vld) begin
      if (h_q.hv && h_d.hv) begin
        h_d.ovr = 1'b1;
      end else begin
        h_d.hold = {r_ferr, r_perr, r_data};
        h_d.hv = 1'b1;
      end
    end
    if (h_q.rcnt != '0) begin
      h_d.rcnt = h_q.rcnt - 17'h0_0001;
    end
    h_d.rpin = h_d.rcnt != '0;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_q <= HOST_RST;
    end else begin
      h_q <= h_d;
    end
  end

  // Clear-to-send held high while the receive holding register is full
  assign link.clear_send_in_n = h_q.hv;
  assign link.reset_input_pin = h_q.rpin;
  assign prdata_o = h_q.rdata;
  assign pready_o = h_q.ready;
  assign pslverr_o = h_q.err;
endmodule

// ==== umb_link_chk.sv ====
// Concurrent checks on the serial link joining the two ends
`timescale 1ns/1ps
module umb_link_chk #(
  parameter int HOST_RST_CYC = umb_pkg::HOST_RST_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reset_input_pin,
  input wire logic dev_rxd,
  input wire logic dev_txd,
  input wire logic request_send_out_n,
  input wire logic clear_send_in_n
);
  // Longest legal low run: a break at the slowest rate the bench uses
  localparam int LOW_MAX = 25300;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      hi_q <= reset_input_pin ? hi_q + 16'h0001 : 16'h0000;
      lo_q <= dev_txd ? 16'h0000 : lo_q + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Start bit spans at least three clocks at the fastest rate
  sequence s_start(sig);
    (!sig) [*3];
  endsequence
  a_link_idle_reset: assert property ($rose(rst_b_i) |-> dev_txd && dev_rxd && request_send_out_n
    && !clear_send_in_n && !reset_input_pin) else $error("link not idle after reset");
  a_txd_start_width: assert property ($fell(dev_txd) |-> s_start(dev_txd))
    else $error("module start bit too short");
  a_rxd_start_width: assert property ($fell(dev_rxd) |-> s_start(dev_rxd))
    else $error("host start bit too short");
  a_cts_gates_tx: assert property ($fell(dev_txd) |-> $past(!clear_send_in_n))
    else $error("module sent while clear-to-send high");
  a_rts_gates_host: assert property ($fell(dev_rxd) |-> $past(!request_send_out_n)
    || $past(!request_send_out_n, 2)) else $error("host sent while request-to-send high");
  a_pin_pulse_len: assert property ($fell(reset_input_pin) |-> hi_q == HOST_RST_CYC)
    else $error("reset pulse length wrong");
  a_pin_rise_hold: assert property ($rose(reset_input_pin) |-> reset_input_pin [*8])
    else $error("reset pulse cut short");
  a_txd_low_bound: assert property (lo_q <= LOW_MAX)
    else $error("transmit line low too long");
endmodule

// ==== umb_link_if.sv ====
// Serial link between the module end and the host end
`timescale 1ns/1ps
interface umb_link_if;
  logic reset_input_pin;
  logic dev_rxd;
  logic dev_txd;
  logic request_send_out_n;
  logic clear_send_in_n;
  modport dev (input reset_input_pin, input dev_rxd, output dev_txd, output request_send_out_n,
               input clear_send_in_n);
  modport host (output reset_input_pin, output dev_rxd, input dev_txd, input request_send_out_n,
                output clear_send_in_n);
endinterface

// ==== umb_pkg.sv ====
// Shared constants, types and helpers for the serial port with break reset
package umb_pkg;
  localparam int CLK_MHZ = 10;
  // Bit rate equals the baud setting divided by 0.004096
  localparam int BAUD_SCALE = 4096;
  localparam logic [16:0] BAUD_MOD = 17'(CLK_MHZ * BAUD_SCALE);
  localparam logic [16:0] BAUD_HALF = BAUD_MOD >> 1;
  localparam logic [15:0] BAUD_RST = 16'h01d8;
  localparam logic [15:0] BRK_TIMEOUT_RST = 16'h01a4;
  localparam int RST_FILT_US = 1500;
  localparam int RST_FILT_CYC = RST_FILT_US * CLK_MHZ;
  localparam int HOST_RST_US = 5000;
  localparam int HOST_RST_CYC = HOST_RST_US * CLK_MHZ + 1;
  localparam int BRK_UNIT_US = 1000;
  localparam int BRK_UNIT_CYC = BRK_UNIT_US * CLK_MHZ;
  localparam logic [4:0] TX_BRK_BITS = 5'h18;
  localparam int GIO_N = 6;
  localparam logic [1:0] PULL_WEAK_UP = 2'h0;
  localparam logic [2*GIO_N-1:0] GIO_PULL_RST = {GIO_N{PULL_WEAK_UP}};
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int CTRL_PAR_LSB = 16;
  localparam int CTRL_STOP2 = 18;
  localparam int CTRL_FLOW = 19;
  localparam int CMD_RST = 0;
  localparam int CMD_BRK = 1;
  localparam int RX_VLD = 8;
  localparam int RX_PERR = 9;
  localparam int RX_FERR = 10;
  localparam int STAT_EMPTY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_RXV = 2;
  localparam int STAT_OVR = 3;
  localparam int STAT_RBUSY = 4;
  localparam int STAT_TBUSY = 5;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01, PAR_EVEN = 2'b10} umb_par_e;
  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011,
                            TX_STOP = 3'b100, TX_BRK = 3'b101} umb_tx_e;
  typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011,
                            RX_STOP = 3'b100} umb_rx_e;

  // Fractional bit clock step: {tick, new accumulator}
  function automatic logic [17:0] umb_nco(input logic [16:0] acc, input logic [15:0] inc);
    logic [16:0] sum;
    sum = acc + {1'b0, inc};
    if (sum >= BAUD_MOD) begin
      umb_nco = {1'b1, 17'(sum - BAUD_MOD)};
    end else begin
      umb_nco = {1'b0, sum};
    end
  endfunction
endpackage
